/* File: lcsb_status_bits.sv */
// Loop flags, double-precision multiply and sixteen-bit compatibility status bits.
// Assumes the loop hardware, system stack, ALU decode and move path share I_SYS_CLK.
`timescale 1ns/1ps

// How it works
// RULE_01: Starting an endless loop sets the endless-loop flag, status bit 16.
// RULE_02: Loop start pushes the endless flag; loop end restores it from the stack.
// RULE_03: Return from long interrupt restores the endless flag from pulled stack value.
// RULE_04: Loop-active flag, status bit 15, enables loop end detection.
// RULE_05: Loop start stacks the loop-active flag; loop end restores it.
// RULE_06: Return from long interrupt restores the loop-active flag from the stack.
// RULE_07: Double-precision bit 14 enables the four-operation 48x48 multiply mode.
// RULE_08: Only the four listed operations with listed registers change behaviour.
// RULE_09: The sequence uses the multiplier input register at every stage.
// RULE_10: Compat bit 13 set: moves with loop/stack/vector registers clear top byte.
// RULE_11: Compat set: moves sourced from status or mode register clear top byte.
// RULE_12: Compat set: moves into status or mode register keep their top byte.
// RULE_13: Compat clear: count zero skips loop, all-ones runs 2^24-1 times.
// RULE_14: Compat set: count zero runs 2^16 times, all-ones 2^16-1 times.
// RULE_15: A compat bit change takes effect after three instruction cycles.
// RULE_16: Reset clears all four bits.
module lcsb_status_bits (
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_RST,
  input  wire logic                 I_INSTR_STEP,
  input  wire logic                 I_LOOP_START,
  input  wire logic                 I_LOOP_FOREVER,
  input  wire logic                 I_LOOP_END,
  input  wire lcsb_pkg::lcsb_flags_t I_POP_FLAGS,
  input  wire logic                 I_RTI,
  input  wire logic [23:0]          I_RTI_STATUS,
  input  wire logic                 I_AT_LOOP_END,
  input  wire logic                 I_DP_OP,
  input  wire logic                 I_DP_REGS,
  input  wire logic                 I_MOVE_VALID,
  input  wire lcsb_pkg::lcsb_move_t  I_MOVE,
  input  wire logic                 I_LC_LOAD,
  input  wire logic [23:0]          I_LC_VALUE,
  output logic [23:0]               O_STATUS,
  output logic                      O_PUSH_VALID,
  output lcsb_pkg::lcsb_flags_t      O_PUSH_FLAGS,
  output logic                      O_LOOP_END_HIT,
  output logic                      O_DP_STAGE,
  output logic                      O_DP_MIR_SEL,
  output logic                      O_MOVE_VALID,
  output logic [23:0]               O_MOVE_DATA,
  output logic                      O_LC_VALID,
  output logic [24:0]               O_LC_ITER,
  output logic                      O_LC_SKIP
);
  localparam int unsigned LO_W = lcsb_pkg::LCSB_W - lcsb_pkg::LCSB_HI_W;

  logic        endless;
  logic        active;
  logic        dp_mode;
  logic        compat;
  logic [lcsb_pkg::LCSB_CMP_DELAY-1:0] compat_pipe;
  logic        compat_eff;

  logic        next_endless;
  logic        next_active;
  logic        next_dp_mode;
  logic        next_compat;

  // Decode of the move
  wire logic pcu_src = (I_MOVE.src >= lcsb_pkg::LCSB_R_LOOP_END)
                    && (I_MOVE.src <= lcsb_pkg::LCSB_R_VEC_BASE);
  wire logic pcu_dst = (I_MOVE.dst >= lcsb_pkg::LCSB_R_LOOP_END)
                    && (I_MOVE.dst <= lcsb_pkg::LCSB_R_VEC_BASE);
  wire logic sm_src  = (I_MOVE.src == lcsb_pkg::LCSB_R_STATUS)
                    || (I_MOVE.src == lcsb_pkg::LCSB_R_OPMODE);
  wire logic sm_dst  = (I_MOVE.dst == lcsb_pkg::LCSB_R_STATUS)
                    || (I_MOVE.dst == lcsb_pkg::LCSB_R_OPMODE);
  wire logic st_dst  = I_MOVE_VALID && (I_MOVE.dst == lcsb_pkg::LCSB_R_STATUS);
  // A move into status or mode keeps its top byte, even when its source would clear it
  wire logic keep_hi = compat_eff && sm_dst;
  wire logic clr_hi  = compat_eff && !keep_hi && (pcu_src || pcu_dst || sm_src);
  wire logic [23:0] move_res =
      keep_hi ? {I_MOVE.old[23:LO_W], I_MOVE.data[LO_W-1:0]} :
      clr_hi  ? {{lcsb_pkg::LCSB_HI_W{1'b0}}, I_MOVE.data[LO_W-1:0]} :
                I_MOVE.data;

  // Loop count interpretation
  wire logic [24:0] iter_norm = {1'b0, I_LC_VALUE};
  wire logic [15:0] cnt_lo    = I_LC_VALUE[lcsb_pkg::LCSB_CMP_CNT_W-1:0];
  wire logic [24:0] iter_cmp  = (cnt_lo == 16'h0000) ? lcsb_pkg::LCSB_CMP_ZERO
                                                     : {9'h000, cnt_lo};
  wire logic [24:0] iter_sel  = compat_eff ? iter_cmp : iter_norm;

  assign compat_eff = compat_pipe[lcsb_pkg::LCSB_CMP_DELAY-1]; // RULE_15

  always_comb begin
    O_STATUS = 24'h000000;
    O_STATUS[lcsb_pkg::LCSB_BIT_ENDL] = endless;
    O_STATUS[lcsb_pkg::LCSB_BIT_LACT] = active;
    O_STATUS[lcsb_pkg::LCSB_BIT_DPM]  = dp_mode;
    O_STATUS[lcsb_pkg::LCSB_BIT_CMP]  = compat;
  end

  assign O_LOOP_END_HIT = active && I_AT_LOOP_END;            // RULE_04
  assign O_DP_STAGE     = dp_mode && I_DP_OP && I_DP_REGS;    // RULE_07 RULE_08
  assign O_DP_MIR_SEL   = O_DP_STAGE;                         // RULE_09

  // Priority: interrupt return, then loop end, then loop start, then move
  always_comb begin
    next_endless = endless;
    next_active  = active;
    next_dp_mode = dp_mode;
    next_compat  = compat;
    if (I_RTI) begin
      next_endless = I_RTI_STATUS[lcsb_pkg::LCSB_BIT_ENDL];   // RULE_03
      next_active  = I_RTI_STATUS[lcsb_pkg::LCSB_BIT_LACT];   // RULE_06
    end else if (I_LOOP_END) begin
      next_endless = I_POP_FLAGS.endless;                     // RULE_02
      next_active  = I_POP_FLAGS.active;                      // RULE_05
    end else if (I_LOOP_START) begin
      next_endless = I_LOOP_FOREVER;                          // RULE_01
      next_active  = 1'b1;                                    // RULE_04
    end else if (st_dst) begin
      next_endless = move_res[lcsb_pkg::LCSB_BIT_ENDL];       // RULE_12
      next_active  = move_res[lcsb_pkg::LCSB_BIT_LACT];
    end
    if (st_dst) begin
      next_dp_mode = move_res[lcsb_pkg::LCSB_BIT_DPM];        // RULE_07
      next_compat  = move_res[lcsb_pkg::LCSB_BIT_CMP];
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      endless <= lcsb_pkg::LCSB_RST_BIT;                       // RULE_16
      active  <= lcsb_pkg::LCSB_RST_BIT;
      dp_mode <= lcsb_pkg::LCSB_RST_BIT;
      compat  <= lcsb_pkg::LCSB_RST_BIT;
    end else begin
      endless <= next_endless;
      active  <= next_active;
      dp_mode <= next_dp_mode;
      compat  <= next_compat;
    end
  end

  // Move results lag the bit by three instruction steps, as the pipeline does
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      compat_pipe <= '0;
    end else if (I_INSTR_STEP) begin
      compat_pipe <= {compat_pipe[lcsb_pkg::LCSB_CMP_DELAY-2:0], compat}; // RULE_15
    end
  end

  // Stack push of the flags in force before the loop starts
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PUSH_VALID <= 1'b0;
      O_PUSH_FLAGS <= '0;
    end else begin
      O_PUSH_VALID <= I_LOOP_START && !I_LOOP_END && !I_RTI;   // RULE_02 RULE_05
      if (I_LOOP_START) begin
        O_PUSH_FLAGS <= '{endless: endless, active: active};
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MOVE_VALID <= 1'b0;
      O_MOVE_DATA  <= 24'h000000;
    end else begin
      O_MOVE_VALID <= I_MOVE_VALID;
      if (I_MOVE_VALID) begin
        O_MOVE_DATA <= move_res;                               // RULE_10 RULE_11 RULE_12
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_LC_VALID <= 1'b0;
      O_LC_ITER  <= 25'h0000000;
      O_LC_SKIP  <= 1'b0;
    end else begin
      O_LC_VALID <= I_LC_LOAD;
      if (I_LC_LOAD) begin
        O_LC_ITER <= iter_sel;                                 // RULE_13 RULE_14
        O_LC_SKIP <= (iter_sel == 25'h0000000);
      end
    end
  end

  // Helper: instruction steps seen since the compat bit last changed
  logic [1:0] steps_seen;
  logic       compat_d;
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      steps_seen <= 2'h3;
      compat_d   <= 1'b0;
    end else begin
      compat_d <= compat;
      if (compat != compat_d) begin
        steps_seen <= I_INSTR_STEP ? 2'h1 : 2'h0;
      end else if (I_INSTR_STEP && steps_seen != 2'h3) begin
        steps_seen <= steps_seen + 2'h1;
      end
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  sequence s_plain_start;
    I_LOOP_START && !I_LOOP_END && !I_RTI;
  endsequence

  property p_start_forever;
    s_plain_start ##0 I_LOOP_FOREVER |=> endless && active;
  endproperty
  a_start_forever: assert property (p_start_forever) // RULE_01
    else $error("endless loop start did not set flags");

  property p_push_old;
    s_plain_start |=> O_PUSH_VALID && O_PUSH_FLAGS == {$past(endless), $past(active)};
  endproperty
  a_push_old: assert property (p_push_old) // RULE_02
    else $error("loop start did not push prior flags");

  property p_end_restore;
    I_LOOP_END && !I_RTI |=> {endless, active} == $past(I_POP_FLAGS);
  endproperty
  a_end_restore: assert property (p_end_restore) // RULE_05
    else $error("loop end did not restore flags");

  property p_rti_restore;
    I_RTI |=> endless == $past(I_RTI_STATUS[16]) && active == $past(I_RTI_STATUS[15]);
  endproperty
  a_rti_restore: assert property (p_rti_restore) // RULE_03
    else $error("interrupt return did not restore loop flags");

  property p_end_detect;
    I_AT_LOOP_END && !O_STATUS[15] |-> !O_LOOP_END_HIT;
  endproperty
  a_end_detect: assert property (p_end_detect) // RULE_04
    else $error("loop end hit without active flag");

  property p_dp_gate;
    O_DP_STAGE |-> O_STATUS[14] && I_DP_OP && I_DP_REGS && O_DP_MIR_SEL;
  endproperty
  a_dp_gate: assert property (p_dp_gate) // RULE_08
    else $error("double-precision stage outside its operations");

  // Until three steps have passed since a change, the old value must still be in force
  property p_compat_wait;
    steps_seen != 2'h3 && compat == compat_d |-> compat_eff != compat;
  endproperty
  a_compat_wait: assert property (p_compat_wait) // RULE_15
    else $error("compat change took effect too early");

  property p_compat_settle;
    steps_seen == 2'h3 && compat == compat_d |-> compat_eff == compat;
  endproperty
  a_compat_settle: assert property (p_compat_settle) // RULE_15
    else $error("compat change not in effect after three steps");

  property p_clear_top;
    I_MOVE_VALID && compat_eff && !sm_dst && (pcu_src || sm_src)
      |=> O_MOVE_DATA[23:16] == 8'h00;
  endproperty
  a_clear_top: assert property (p_clear_top) // RULE_11
    else $error("compat move did not clear top byte");

  property p_keep_top;
    I_MOVE_VALID && compat_eff && sm_dst |=> O_MOVE_DATA[23:16] == $past(I_MOVE.old[23:16]);
  endproperty
  a_keep_top: assert property (p_keep_top) // RULE_12
    else $error("compat move into status altered top byte");

  property p_count_zero;
    I_LC_LOAD && I_LC_VALUE == 24'h000000
      |=> O_LC_VALID && O_LC_SKIP == !$past(compat_eff);
  endproperty
  a_count_zero: assert property (p_count_zero) // RULE_14
    else $error("zero loop count misread");

  property p_count_max;
    I_LC_LOAD && I_LC_VALUE == 24'hFFFFFF && !compat_eff |=> O_LC_ITER == 25'h0FFFFFF;
  endproperty
  a_count_max: assert property (p_count_max) // RULE_13
    else $error("full loop count misread");
endmodule

/* File: lcsb_pkg.sv */
// Package for the loop and compatibility status bits block.
// Assumes a 24-bit status word and a single core clock.
package lcsb_pkg;
  localparam int unsigned LCSB_W         = 24;
  localparam int unsigned LCSB_BIT_ENDL  = 16;
  localparam int unsigned LCSB_BIT_LACT  = 15;
  localparam int unsigned LCSB_BIT_DPM   = 14;
  localparam int unsigned LCSB_BIT_CMP   = 13;
  localparam int unsigned LCSB_CMP_DELAY = 3;
  localparam int unsigned LCSB_HI_W      = 8;
  localparam int unsigned LCSB_CMP_CNT_W = 16;
  localparam logic [23:0] LCSB_MAX_CNT   = 24'hFFFFFF;
  localparam logic [24:0] LCSB_CMP_ZERO  = 25'h0010000;
  localparam logic        LCSB_RST_BIT   = 1'h0;

  // Register selector on the move datapath
  typedef enum logic [3:0] {
    LCSB_R_OTHER    = 4'h0,
    LCSB_R_LOOP_END = 4'h1,
    LCSB_R_LOOP_CNT = 4'h2,
    LCSB_R_STK_PTR  = 4'h3,
    LCSB_R_STK_LO   = 4'h4,
    LCSB_R_STK_HI   = 4'h5,
    LCSB_R_STK_EXT  = 4'h6,
    LCSB_R_STK_SIZE = 4'h7,
    LCSB_R_VEC_BASE = 4'h8,
    LCSB_R_STATUS   = 4'h9,
    LCSB_R_OPMODE   = 4'hA
  } lcsb_reg_t;

  // Loop flags as saved on the system stack
  typedef struct packed {
    logic endless;
    logic active;
  } lcsb_flags_t;

  // One move on the datapath
  typedef struct packed {
    lcsb_reg_t   src;
    lcsb_reg_t   dst;
    logic [23:0] data;
    logic [23:0] old;
  } lcsb_move_t;
endpackage

/* File: lcsb_status_bits_tb.sv */
// Self-checking bench for the loop and compatibility status bits block.
// Assumes lcsb_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module lcsb_status_bits_tb;
  logic                  clk, rst, step, lstart, lforever, lend, return_from_interrupt, atend;
  logic                  dpop, dpregs, mvalid, lcload, pushv, endhit, dpstage;
  logic                  mirsel, movev, lcv, lcskip, cmp_eff;
  lcsb_pkg::lcsb_flags_t popf, pushf;
  lcsb_pkg::lcsb_move_t  mv;
  logic [23:0]           rtist, lcval, status, mdata;
  logic [24:0]           lciter;
  int                    err_count, comparisons, seed, i;

  lcsb_status_bits i_lcsb_status_bits (
    .I_SYS_CLK(clk), .I_RST(rst), .I_INSTR_STEP(step), .I_LOOP_START(lstart),
    .I_LOOP_FOREVER(lforever), .I_LOOP_END(lend), .I_POP_FLAGS(popf), .I_RTI(return_from_interrupt),
    .I_RTI_STATUS(rtist), .I_AT_LOOP_END(atend), .I_DP_OP(dpop), .I_DP_REGS(dpregs),
    .I_MOVE_VALID(mvalid), .I_MOVE(mv), .I_LC_LOAD(lcload), .I_LC_VALUE(lcval),
    .O_STATUS(status), .O_PUSH_VALID(pushv), .O_PUSH_FLAGS(pushf),
    .O_LOOP_END_HIT(endhit), .O_DP_STAGE(dpstage), .O_DP_MIR_SEL(mirsel),
    .O_MOVE_VALID(movev), .O_MOVE_DATA(mdata), .O_LC_VALID(lcv), .O_LC_ITER(lciter),
    .O_LC_SKIP(lcskip));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [24:0] seen, input logic [24:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc();
    @(posedge clk);
    #1;
  endtask

  // Masking as the bench expects it, from the delayed compat state
  function automatic logic [23:0] exp_move(input lcsb_pkg::lcsb_move_t m);
    if (cmp_eff && (m.dst == lcsb_pkg::LCSB_R_STATUS || m.dst == lcsb_pkg::LCSB_R_OPMODE))
      return {m.old[23:16], m.data[15:0]};
    if (cmp_eff && (m.src != lcsb_pkg::LCSB_R_OTHER || m.dst != lcsb_pkg::LCSB_R_OTHER))
      return {8'h00, m.data[15:0]};
    return m.data;
  endfunction

  // Each strobe task except steps lets an idle edge pass first, so back-to-back calls never
  // raise a strobe in the same time step that lowered it
  task automatic mov(input int s, input int d, input logic [23:0] data, input logic [23:0] old);
    cyc();
    mv = '{lcsb_pkg::lcsb_reg_t'(s), lcsb_pkg::lcsb_reg_t'(d), data, old};
    mvalid = 1'b1;
    cyc();
    mvalid = 1'b0;
    check("move valid", movev, 1'b1);
    check("move data", mdata, exp_move(mv));
  endtask

  task automatic lc(input logic [23:0] v, input logic [24:0] it, input logic sk);
    cyc();
    lcval = v;
    lcload = 1'b1;
    cyc();
    lcload = 1'b0;
    check("loop valid", lcv, 1'b1);
    check("loop iterations", lciter, it);
    check("loop skip", lcskip, sk);
  endtask

  task automatic steps(input int n);
    step = 1'b1;
    repeat (n) cyc();
    step = 1'b0;
  endtask

  task automatic rnd_moves(input int n);
    int s, d;
    repeat (n) begin
      s = $unsigned($random(seed)) % 11;
      d = $unsigned($random(seed)) % 11;
      if (d == 9)
        d = 10;
      mov(s, d, 24'($random(seed)), 24'($random(seed)));
    end
  endtask

  task automatic loop_evt(input logic st, input logic fv, input logic en, input logic [1:0] pf);
    cyc();
    {lstart, lforever, lend, popf} = {st, fv, en, pf};
    cyc();
    {lstart, lforever, lend} = 3'h0;
  endtask

  initial begin
    {step, lstart, lforever, lend, return_from_interrupt, atend, dpop, dpregs, mvalid, lcload} = 10'h000;
    {popf, rtist, lcval, mv, cmp_eff} = '0;
    {err_count, comparisons, seed} = {32'h0, 32'h0, 32'h38};
    rst = 1'b1;
    repeat (8) @(posedge clk);
    check("status in reset", status, 24'h000000);
    #1 rst = 1'b0;
    loop_evt(1'b1, 1'b1, 1'b0, 2'h0);
    check("flags after endless start", status[16:15], 2'h3);
    check("push valid", pushv, 1'b1);
    check("pushed flags", pushf, 2'h0);
    cyc();
    check("push pulse width", pushv, 1'b0);
    loop_evt(1'b1, 1'b0, 1'b0, 2'h0);
    check("nested pushed flags", pushf, 2'h3);
    atend = 1'b1;
    #1 check("end detect", endhit, 1'b1);
    loop_evt(1'b0, 1'b0, 1'b1, 2'h1);
    check("flags after pop", status[16:15], 2'h1);
    loop_evt(1'b1, 1'b1, 1'b1, 2'h0);
    check("end beats start", {pushv, status[16:15]}, 3'h0);
    check("no end detect idle", endhit, 1'b0);
    atend = 1'b0;
    for (i = 0; i < 4; i++) begin
      cyc();
      rtist = 24'($random(seed));
      rtist[16:15] = i[1:0];
      {return_from_interrupt, lstart, lforever} = {1'b1, i[0], 1'b1};
      cyc();
      {return_from_interrupt, lstart, lforever} = 3'h0;
      check("flags after return", status[16:15], i[1:0]);
    end
    mov(0, 9, 24'h004000, status);
    check("mode bits", status[16:13], 4'h2);
    for (i = 0; i < 4; i++) begin
      {dpop, dpregs} = i[1:0];
      #1 check("dp stage", dpstage, i == 3);
      check("dp multiplier input", mirsel, i == 3);
    end
    mov(0, 9, 24'h000000, status);
    #1 check("dp disabled", dpstage, 1'b0);
    {dpop, dpregs} = 2'h0;
    lc(24'h000000, 25'h0000000, 1'b1);
    lc(lcsb_pkg::LCSB_MAX_CNT, 25'h0FFFFFF, 1'b0);
    lcval = 24'($random(seed));
    lc(lcval, {1'b0, lcval}, lcval == 24'h0);
    rnd_moves(20);
    mov(0, 9, 24'h002000, status);
    check("compat bit", status[13], 1'b1);
    steps(2);
    lc(24'h000000, 25'h0000000, 1'b1);
    steps(1);
    cmp_eff = 1'b1;
    lc(24'h000000, lcsb_pkg::LCSB_CMP_ZERO, 1'b0);
    lc(lcsb_pkg::LCSB_MAX_CNT, 25'h000FFFF, 1'b0);
    rnd_moves(40);
    loop_evt(1'b1, 1'b1, 1'b0, 2'h0);
    mov(0, 9, 24'h002000, status);
    check("top byte kept", status[16], 1'b1);
    mov(9, 0, status, 24'h000000);
    mov(10, 1, 24'hFFFFFF, 24'h000000);
    mov(0, 9, 24'h000000, status);
    steps(3);
    cmp_eff = 1'b0;
    rnd_moves(20);
    print_verdict();
  end

  // Whole run is a few hundred cycles
  initial begin
    #(40 * 5000);
    err_count++;
    print_verdict();
  end
endmodule
